// *** hw/ecct_params.svh ***
// Register offsets, field positions, reset values and timing counts of the capture/compare timer
`ifndef ECCT_PARAMS_SVH
`define ECCT_PARAMS_SVH

// Register offsets on the plain register port
`define ECCT_OFF_COUNT     4'h0
`define ECCT_OFF_CMPA      4'h1
`define ECCT_OFF_CAPCMP    4'h2
`define ECCT_OFF_CAPONLY   4'h3
`define ECCT_OFF_TCTRL     4'h4
`define ECCT_OFF_PRESC     4'h5
`define ECCT_OFF_CCCTRL    4'h6
`define ECCT_OFF_EDGE      4'h7
`define ECCT_OFF_SAMP      4'h8
`define ECCT_OFF_STAT      4'h9
`define ECCT_OFF_IEN       4'hA
`define ECCT_OFF_ICLR      4'hB

// Field positions
`define ECCT_TC_RUN        0
`define ECCT_TC_AUX        1
`define ECCT_TC_ARMED      7
`define ECCT_CC_CLRA       0
`define ECCT_CC_CLRB       1
`define ECCT_CC_CAPT       2
`define ECCT_IRQ_CMPA      0
`define ECCT_IRQ_CMPB      1
`define ECCT_IRQ_PIN       2

// Reset values
`define ECCT_RST_BYTE      8'h00
`define ECCT_RST_PRESC     4'h0
`define ECCT_RST_CCCTRL    3'h0
`define ECCT_RST_SAMP      2'h0
`define ECCT_RST_IRQ       3'h0

// Timing: count period is 2^(select+3) clocks, select 0..8 gives x = 8..2048
`define ECCT_PRESC_BASE    4'h3
`define ECCT_PRESC_MAXSEL  4'h8
`define ECCT_PRESC_EXTSEL  4'h9
`define ECCT_DIV_LOGMAX    4'hB
`define ECCT_SAMP_LOG1     4'h6
`define ECCT_SAMP_LOG2     4'h7
`define ECCT_SAMP_LOG3     4'h8
`define ECCT_MIN_SAMPLES   3

`endif

// *** hw/ecct_pkg.sv ***
// Types shared by the capture/compare timer modules
package ecct_pkg;

    typedef enum logic [1:0] {
        ECCT_EDGE_FALL = 2'h0,
        ECCT_EDGE_RISE = 2'h1,
        ECCT_EDGE_BOTH = 2'h3,
        ECCT_EDGE_NONE = 2'h2
    } ecct_edge_type;

    typedef struct packed {
        logic [10:0] div;
        logic        cntTick;
        logic        smpTick;
    } ecct_presc_type;

    typedef struct packed {
        logic [2:0] sync;
        logic       pinLvl;
        logic [2:0] hist;
        logic       level;
        logic       edgePulse;
    } ecct_edgedet_type;

    typedef struct packed {
        logic [7:0]    count;
        logic [7:0]    cmpA;
        logic [7:0]    ccVal;
        logic [7:0]    capVal;
        logic          run;
        logic          aux;
        logic          armed;
        logic [3:0]    presSel;
        logic [2:0]    ccCtl;
        ecct_edge_type edgeMode;
        logic [1:0]    sampSel;
        logic [2:0]    status;
        logic [2:0]    intEn;
        logic [7:0]    rdData;
        logic          irq;
    } ecct_timer_type;

endpackage

// *** hw/ecct_prescaler.sv ***
// Free-running divider giving the count tick and the sampling tick
`timescale 1ns/1ps
`include "ecct_params.svh"
module ecct_prescaler (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic [3:0] cntSel,
    input  wire logic [1:0] smpSel,
    output logic            cntTick,
    output logic            smpTick
);
    import ecct_pkg::*;

    ecct_pkg::ecct_presc_type state_reg;
    ecct_pkg::ecct_presc_type state_next;

    // Low-bit mask for a divide by 2^lg
    function automatic logic [10:0] divMask(input logic [3:0] lg);
        divMask = 11'h7FF >> (`ECCT_DIV_LOGMAX - lg);
    endfunction

    // Tick once per period; ticks are phase-locked to the free divider
    always_comb begin
        logic [10:0] cm;
        logic [10:0] sm;
        sm = 11'h000;
        cm = divMask(cntSel + `ECCT_PRESC_BASE);
        case (smpSel)
            2'h1:    sm = divMask(`ECCT_SAMP_LOG1);
            2'h2:    sm = divMask(`ECCT_SAMP_LOG2);
            2'h3:    sm = divMask(`ECCT_SAMP_LOG3);
            default: sm = 11'h000;
        endcase
        state_next = state_reg;
        state_next.div = state_reg.div + 11'h001;
        state_next.cntTick = (cntSel <= `ECCT_PRESC_MAXSEL) && ((state_reg.div & cm) == cm);
        state_next.smpTick = (state_reg.div & sm) == sm;
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign cntTick = state_reg.cntTick;
    assign smpTick = state_reg.smpTick;
endmodule

// *** hw/ecct_edge_detect.sv ***
// Event pin synchroniser, three-sample noise filter and valid-edge selector
`timescale 1ns/1ps
`include "ecct_params.svh"
module ecct_edge_detect (
    input  wire logic                    ref_clk,
    input  wire logic                    srst,
    input  wire logic                    pinIn,
    input  wire logic                    smpTick,
    input  wire ecct_pkg::ecct_edge_type edgeMode,
    output logic                         edgePulse
);
    import ecct_pkg::*;

    ecct_pkg::ecct_edgedet_type state_reg;
    ecct_pkg::ecct_edgedet_type state_next;

    // Level accepted only when it held for the minimum sample count
    always_comb begin
        logic rise;
        logic fall;
        rise = 1'b0;
        fall = 1'b0;
        state_next = state_reg;
        state_next.sync = {state_reg.sync[1:0], pinIn};
        if (state_reg.sync[1] == state_reg.sync[2]) begin
            state_next.pinLvl = state_reg.sync[2];
        end
        if (smpTick) begin
            state_next.hist = {state_reg.hist[1:0], state_reg.pinLvl};
            rise = (state_next.hist == {`ECCT_MIN_SAMPLES{1'b1}}) && !state_reg.level;
            fall = (state_next.hist == {`ECCT_MIN_SAMPLES{1'b0}}) && state_reg.level;
            if (rise || fall) begin
                state_next.level = !state_reg.level;
            end
        end
        case (edgeMode)
            ECCT_EDGE_FALL: state_next.edgePulse = fall;
            ECCT_EDGE_RISE: state_next.edgePulse = rise;
            ECCT_EDGE_BOTH: state_next.edgePulse = rise || fall;
            default:        state_next.edgePulse = 1'b0;
        endcase
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign edgePulse = state_reg.edgePulse;
endmodule

// *** hw/ecct_timer.sv ***
// Event capture/compare timer: 8-bit up counter, one compare, one capture/compare and one capture-only path
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "ecct_params.svh"
module ecct_timer (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wrData,
    input  wire logic       wrEn,
    input  wire logic       rdEn,
    output logic [7:0]      rdData,
    input  wire logic       eventPin,
    output logic            irq
);
    import ecct_pkg::*;

    ecct_pkg::ecct_timer_type state_reg;
    ecct_pkg::ecct_timer_type state_next;

    logic cntTick;
    logic smpTick;
    logic edgePulse;

    // Count period and sampling clock generator
    ecct_prescaler u_prescaler (
        .ref_clk (ref_clk),
        .srst    (srst),
        .cntSel  (state_reg.presSel),
        .smpSel  (state_reg.sampSel),
        .cntTick (cntTick),
        .smpTick (smpTick)
    );

    // Event pin filter; short levels never reach the edge output
    ecct_edge_detect u_edge_detect (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .pinIn     (eventPin),
        .smpTick   (smpTick),
        .edgeMode  (state_reg.edgeMode),
        .edgePulse (edgePulse)
    );

    // Write strobe decode for one register offset
    function automatic logic wrHit(input logic [3:0] off);
        wrHit = wrEn && (addr == off);
    endfunction

    // Zero-extend a three-bit flag group to a data byte
    function automatic logic [7:0] flagByte(input logic [2:0] f);
        flagByte = {5'h00, f};
    endfunction

    // Decoded controls and events of the current cycle
    logic       extMode;
    logic       captMode;
    logic       clrOnA;
    logic       clrOnB;
    logic       countTick;
    logic       armNow;
    logic       hitA;
    logic       hitB;
    logic       clrNow;
    logic [7:0] incCount;
    logic       matchA;
    logic       matchB;
    logic       capClear;
    logic [2:0] events;
    logic [2:0] clrMask;
    logic       runWrite;
    logic       runBit;

    // Mode decode from the control registers
    always_comb begin
        extMode  = state_reg.presSel == `ECCT_PRESC_EXTSEL;
        captMode = state_reg.ccCtl[`ECCT_CC_CAPT];
        clrOnA   = state_reg.ccCtl[`ECCT_CC_CLRA];
        clrOnB   = state_reg.ccCtl[`ECCT_CC_CLRB] && !captMode;
        runWrite = wrHit(`ECCT_OFF_TCTRL);
        runBit   = wrData[`ECCT_TC_RUN];
    end

    // Count clock selection and event arming
    always_comb begin
        countTick = 1'b0;
        armNow    = 1'b0;
        if (state_reg.run) begin
            if (extMode) begin
                // First valid edge only arms, so one edge still reads zero
                armNow    = edgePulse && !state_reg.armed;
                countTick = edgePulse && state_reg.armed;
            end else begin
                countTick = cntTick;
            end
        end
    end

    // Compare logic: next count and match detection on increments only
    always_comb begin
        hitA     = state_reg.count == state_reg.cmpA;
        hitB     = !captMode && (state_reg.count == state_reg.ccVal);
        clrNow   = countTick && ((clrOnA && hitA) || (clrOnB && hitB));
        incCount = clrNow ? 8'h00 : state_reg.count + 8'h01;
        matchA   = countTick && (incCount == state_reg.cmpA)
                   && !wrHit(`ECCT_OFF_CMPA);
        matchB   = countTick && !captMode && (incCount == state_reg.ccVal)
                   && !wrHit(`ECCT_OFF_CAPCMP);
        capClear = edgePulse && captMode && state_reg.aux && state_reg.run;
    end

    // Interrupt event and clear vectors
    always_comb begin
        events = 3'h0;
        events[`ECCT_IRQ_CMPA] = matchA;
        events[`ECCT_IRQ_CMPB] = matchB;
        events[`ECCT_IRQ_PIN]  = edgePulse;
        clrMask = wrHit(`ECCT_OFF_ICLR) ? wrData[2:0] : 3'h0;
    end

    // Next state of the whole block
    always_comb begin
        state_next = state_reg;

        // Counter advance
        if (countTick) begin
            state_next.count = incCount;
        end
        if (armNow) begin
            state_next.armed = 1'b1;
        end

        // Captures on each valid edge; values stay until the next one
        if (edgePulse) begin
            state_next.capVal = state_reg.count;
            if (captMode) begin
                state_next.ccVal = state_reg.count;
            end
        end
        if (capClear) begin
            state_next.count = 8'h00;
        end

        // Compare register writes; a capture in the same cycle wins
        if (wrHit(`ECCT_OFF_CMPA)) begin
            state_next.cmpA = wrData;
        end
        if (wrHit(`ECCT_OFF_CAPCMP) && !(edgePulse && captMode)) begin
            state_next.ccVal = wrData;
        end

        // Run control: start clears the count, stop clears it at once
        if (runWrite) begin
            state_next.aux = wrData[`ECCT_TC_AUX];
            if (runBit && !state_reg.run) begin
                state_next.run   = 1'b1;
                state_next.count = 8'h00;
                state_next.armed = 1'b0;
            end else if (!runBit) begin
                state_next.run   = 1'b0;
                state_next.count = 8'h00;
                state_next.armed = 1'b0;
            end
        end

        // Mode registers, stored as written even while running
        if (wrHit(`ECCT_OFF_PRESC)) begin
            state_next.presSel = wrData[3:0];
        end
        if (wrHit(`ECCT_OFF_CCCTRL)) begin
            state_next.ccCtl = wrData[2:0];
        end
        if (wrHit(`ECCT_OFF_EDGE)) begin
            state_next.edgeMode = ecct_edge_type'(wrData[1:0]);
        end
        if (wrHit(`ECCT_OFF_SAMP)) begin
            state_next.sampSel = wrData[1:0];
        end
        if (wrHit(`ECCT_OFF_IEN)) begin
            state_next.intEn = wrData[2:0];
        end

        // Sticky flags: a new event beats a clear in the same cycle
        state_next.status = (state_reg.status & ~clrMask) | events;

        // Level interrupt from enabled flags
        state_next.irq = |(state_next.status & state_next.intEn);

        // Read port; data stands only in the cycle after the strobe
        state_next.rdData = 8'h00;
        if (rdEn) begin
            case (addr)
                `ECCT_OFF_COUNT: begin
                    state_next.rdData = state_reg.count;
                end
                `ECCT_OFF_CMPA: begin
                    state_next.rdData = state_reg.cmpA;
                end
                `ECCT_OFF_CAPCMP: begin
                    state_next.rdData = state_reg.ccVal;
                end
                `ECCT_OFF_CAPONLY: begin
                    state_next.rdData = state_reg.capVal;
                end
                `ECCT_OFF_TCTRL: begin
                    state_next.rdData[`ECCT_TC_RUN]   = state_reg.run;
                    state_next.rdData[`ECCT_TC_AUX]   = state_reg.aux;
                    state_next.rdData[`ECCT_TC_ARMED] = state_reg.armed;
                end
                `ECCT_OFF_PRESC: begin
                    state_next.rdData = {4'h0, state_reg.presSel};
                end
                `ECCT_OFF_CCCTRL: begin
                    state_next.rdData = flagByte(state_reg.ccCtl);
                end
                `ECCT_OFF_EDGE: begin
                    state_next.rdData = {6'h00, state_reg.edgeMode};
                end
                `ECCT_OFF_SAMP: begin
                    state_next.rdData = {6'h00, state_reg.sampSel};
                end
                `ECCT_OFF_STAT: begin
                    state_next.rdData = flagByte(state_reg.status);
                end
                `ECCT_OFF_IEN: begin
                    state_next.rdData = flagByte(state_reg.intEn);
                end
                default: begin
                    state_next.rdData = 8'h00;
                end
            endcase
        end
    end

    // State register with defined reset values
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg          <= '0;
            state_reg.count    <= `ECCT_RST_BYTE;
            state_reg.cmpA     <= `ECCT_RST_BYTE;
            state_reg.ccVal    <= `ECCT_RST_BYTE;
            state_reg.capVal   <= `ECCT_RST_BYTE;
            state_reg.presSel  <= `ECCT_RST_PRESC;
            state_reg.ccCtl    <= `ECCT_RST_CCCTRL;
            state_reg.edgeMode <= ECCT_EDGE_FALL;
            state_reg.sampSel  <= `ECCT_RST_SAMP;
            state_reg.status   <= `ECCT_RST_IRQ;
            state_reg.intEn    <= `ECCT_RST_IRQ;
            state_reg.rdData   <= `ECCT_RST_BYTE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    assign rdData = state_reg.rdData;
    assign irq    = state_reg.irq;
endmodule

// *** tb/ecct_timer_sva.sv ***
// Port-level assertions for the capture/compare timer and their bind
`timescale 1ns/1ps
`include "ecct_params.svh"
module ecct_timer_sva (
    input wire logic       ref_clk,
    input wire logic       srst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wrData,
    input wire logic       wrEn,
    input wire logic       rdEn,
    input wire logic [7:0] rdData,
    input wire logic       eventPin,
    input wire logic       irq
);
    logic [7:0] cmpAReg;
    logic [2:0] ienReg;
    logic       runReg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    // Shadows of what software last wrote
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cmpAReg <= 8'h00;
            ienReg  <= 3'h0;
            runReg  <= 1'b0;
        end else if (wrEn) begin
            if (addr == `ECCT_OFF_CMPA) cmpAReg <= wrData;
            if (addr == `ECCT_OFF_IEN) ienReg <= wrData[2:0];
            if (addr == `ECCT_OFF_TCTRL) runReg <= wrData[`ECCT_TC_RUN];
        end
    end

    // One read strobe at a given offset
    sequence s_rd(logic [3:0] a);
        rdEn && addr == a;
    endsequence

    a_read_idle_zero: assert property (!$past(rdEn) |-> rdData == 8'h00)
        else $error("read data not zero outside read cycle");
    a_cmpa_read_back: assert property (s_rd(`ECCT_OFF_CMPA) |=> rdData == cmpAReg)
        else $error("compare A read back wrong");
    a_ien_read_back: assert property (s_rd(`ECCT_OFF_IEN) |=> rdData == {5'h00, ienReg})
        else $error("enable read back wrong");
    a_run_read_back: assert property (s_rd(`ECCT_OFF_TCTRL) |=> rdData[0] == runReg)
        else $error("run bit read back wrong");
    a_stopped_count_zero: assert property ((s_rd(`ECCT_OFF_COUNT) ##0 !runReg) |=> rdData == 8'h00)
        else $error("count not zero while stopped");
    a_unmapped_zero: assert property (rdEn && addr >= 4'hC |=> rdData == 8'h00)
        else $error("unmapped read not zero");
    a_clear_reads_zero: assert property (s_rd(`ECCT_OFF_ICLR) |=> rdData == 8'h00)
        else $error("clear register read not zero");
    a_irq_masked: assert property (ienReg == 3'h0 && $past(ienReg) == 3'h0 |-> !irq)
        else $error("interrupt high while all enables off");
endmodule

bind ecct_timer ecct_timer_sva i_sva (
    .ref_clk (ref_clk),
    .srst    (srst),
    .addr    (addr),
    .wrData  (wrData),
    .wrEn    (wrEn),
    .rdEn    (rdEn),
    .rdData  (rdData),
    .eventPin(eventPin),
    .irq     (irq)
);

// *** tb/ecct_pulse_src.sv ***
// Behavioural external pulse source driving the event pin
`timescale 1ns/1ps
module ecct_pulse_src #(
    parameter int MIN_HOLD = 3
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic reqLevel,
    output logic     eventPin
);
    int holdCnt;

    // Follow the requested level only once the present level has stood long enough
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            eventPin <= 1'b0;
            holdCnt  <= 0;
        end else if (reqLevel != eventPin && holdCnt >= MIN_HOLD - 1) begin
            eventPin <= reqLevel;
            holdCnt  <= 0;
        end else if (holdCnt < MIN_HOLD) begin
            holdCnt <= holdCnt + 1;
        end
    end
endmodule

// *** tb/tb.sv ***
// Self-checking testbench of the capture/compare timer
`timescale 1ns/1ps
`include "ecct_params.svh"
module tb;
    localparam int TIME_LIMIT = 30000;
    logic       ref_clk;
    logic       srst     = 1'b1;
    logic [3:0] addr     = 4'h0;
    logic [7:0] wrData   = 8'h00;
    logic       wrEn     = 1'b0;
    logic       rdEn     = 1'b0;
    logic       reqLevel = 1'b0;
    logic [7:0] rdData;
    logic       eventPin;
    logic       irq;
    int         cycleCnt = 0;
    int         nMismatch = 0;
    int         totalChecks = 0;

    ecct_timer i_dut (.ref_clk(ref_clk), .srst(srst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
        .rdEn(rdEn), .rdData(rdData), .eventPin(eventPin), .irq(irq));
    ecct_pulse_src i_src (.ref_clk(ref_clk), .srst(srst), .reqLevel(reqLevel), .eventPin(eventPin));

    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Cycle stamp and hang guard
    always @(posedge ref_clk) begin
        cycleCnt <= cycleCnt + 1;
        if (cycleCnt == TIME_LIMIT) begin
            nMismatch++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Comparisons
    task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        totalChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("BAD %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic check_flag(input string name, input logic exp, input logic got);
        totalChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("BAD %s expected %0b seen %0b", name, exp, got);
        end
    endtask
    task automatic check_count(input string name, input int exp, input int got);
        totalChecks++;
        if (got != exp) begin
            nMismatch++;
            $display("BAD %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    // Register port cycles
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr   <= a;
        wrData <= d;
        wrEn   <= 1'b1;
        @(posedge ref_clk);
        wrEn <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge ref_clk);
        rdEn <= 1'b0;
        #1 d = rdData;
    endtask
    task automatic wait_irq(input logic lvl, input int lim, output int t);
        int k;
        k = 0;
        while (irq !== lvl && k < lim) begin
            @(posedge ref_clk);
            #1 k++;
        end
        t = cycleCnt;
        check_flag("irq level", lvl, irq);
    endtask
    task automatic stop_timer();
        wr(`ECCT_OFF_IEN, 8'h00);
        wr(`ECCT_OFF_TCTRL, 8'h00);
        wr(`ECCT_OFF_ICLR, 8'h07);
    endtask
    task automatic pulse(input int w);
        reqLevel <= 1'b1;
        repeat (w) @(posedge ref_clk);
        reqLevel <= 1'b0;
        repeat (w) @(posedge ref_clk);
    endtask

    // All registers and unmapped offsets read zero after reset
    task automatic t_reset();
        logic [7:0] d;
        for (int a = 0; a < 16; a++) begin
            rd(4'(a), d);
            check_byte("reset value", 8'h00, d);
        end
    endtask

    // Repeating interval with clear on match, then masking
    task automatic t_interval(input logic [3:0] sel, input logic [7:0] n, input logic b);
        int t0, t1, t2, per;
        logic [7:0] d, m;
        per = (int'(n) + 1) << (sel + 3);
        m = b ? 8'h02 : 8'h01;
        stop_timer();
        wr(`ECCT_OFF_PRESC, {4'h0, sel});
        wr(b ? `ECCT_OFF_CAPCMP : `ECCT_OFF_CMPA, n);
        wr(`ECCT_OFF_CCCTRL, m);
        wr(`ECCT_OFF_IEN, m);
        t0 = cycleCnt;
        wr(`ECCT_OFF_TCTRL, 8'h01);
        wait_irq(1'b1, 2 * per + 16, t1);
        check_flag("first interval", 1'b1, t1 - t0 <= per + (1 << (sel + 3)) + 4);
        wr(`ECCT_OFF_ICLR, m);
        wait_irq(1'b0, 6, t2);
        wait_irq(1'b1, per + 4, t2);
        check_count("interval", per, t2 - t1);
        wr(`ECCT_OFF_IEN, 8'h00);
        repeat (2) @(posedge ref_clk);
        #1 check_flag("masked irq", 1'b0, irq);
        rd(`ECCT_OFF_STAT, d);
        check_flag("match flag", 1'b1, |(d & m));
        stop_timer();
    endtask

    // Stop written while every tick matches: counting halts, the flag still rises
    task automatic t_stop_match();
        logic [7:0] d;
        int t;
        wr(`ECCT_OFF_PRESC, 8'h00);
        wr(`ECCT_OFF_CMPA, 8'h00);
        wr(`ECCT_OFF_CCCTRL, 8'h01);
        wr(`ECCT_OFF_IEN, 8'h01);
        wr(`ECCT_OFF_TCTRL, 8'h01);
        wait_irq(1'b1, 32, t);
        wr(`ECCT_OFF_ICLR, 8'h01);
        repeat (4) @(posedge ref_clk);
        wr(`ECCT_OFF_TCTRL, 8'h00);
        rd(`ECCT_OFF_STAT, d);
        check_flag("stop match flag", 1'b1, d[`ECCT_IRQ_CMPA]);
        rd(`ECCT_OFF_COUNT, d);
        check_byte("stop match count", 8'h00, d);
        stop_timer();
    endtask

    // Writing the current count to a compare register gives no match
    task automatic t_write_match();
        logic [7:0] d;
        wr(`ECCT_OFF_PRESC, 8'h08); // Slow ticks keep the count at the written value
        wr(`ECCT_OFF_CCCTRL, 8'h00);
        wr(`ECCT_OFF_TCTRL, 8'h01);
        wr(`ECCT_OFF_CMPA, 8'h00);
        wr(`ECCT_OFF_CAPCMP, 8'h00);
        repeat (20) @(posedge ref_clk);
        rd(`ECCT_OFF_STAT, d);
        check_byte("status after write", 8'h00, d);
        stop_timer();
    endtask

    // Run, agreeing reads, stop zeroes, restart from zero
    task automatic t_stop();
        logic [7:0] a, b;
        int k;
        k = 0;
        wr(`ECCT_OFF_PRESC, 8'h00);
        wr(`ECCT_OFF_TCTRL, 8'h01);
        repeat (50) @(posedge ref_clk);
        do begin
            rd(`ECCT_OFF_COUNT, a);
            rd(`ECCT_OFF_COUNT, b);
            k++;
        end while (a !== b && k < 4);
        check_flag("count running", 1'b1, a != 8'h00);
        wr(`ECCT_OFF_TCTRL, 8'h00);
        rd(`ECCT_OFF_COUNT, a);
        check_byte("count on stop", 8'h00, a);
        repeat (20) @(posedge ref_clk);
        rd(`ECCT_OFF_COUNT, a);
        check_byte("count stopped", 8'h00, a);
        wr(`ECCT_OFF_TCTRL, 8'h01);
        rd(`ECCT_OFF_COUNT, a);
        check_flag("restart count", 1'b1, a <= 8'h01);
        stop_timer();
    endtask

    // Both-edge capture of an 80-cycle pulse, values held afterwards
    task automatic t_capture();
        logic [7:0] c1, c2, c3, d;
        wr(`ECCT_OFF_PRESC, 8'h00);
        wr(`ECCT_OFF_CCCTRL, 8'h04);
        wr(`ECCT_OFF_EDGE, 8'h03);
        wr(`ECCT_OFF_SAMP, 8'h00);
        wr(`ECCT_OFF_TCTRL, 8'h01);
        wr(`ECCT_OFF_ICLR, 8'h07);
        reqLevel <= 1'b1;
        repeat (20) @(posedge ref_clk);
        rd(`ECCT_OFF_CAPCMP, c1);
        repeat (58) @(posedge ref_clk);
        reqLevel <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rd(`ECCT_OFF_CAPCMP, c2);
        rd(`ECCT_OFF_CAPONLY, c3);
        check_byte("capture only", c2, c3);
        check_flag("width", 1'b1, c2 - c1 >= 8'h09 && c2 - c1 <= 8'h0B);
        repeat (60) @(posedge ref_clk);
        rd(`ECCT_OFF_CAPCMP, c3);
        check_byte("capture held", c2, c3);
        rd(`ECCT_OFF_STAT, d);
        check_flag("pin flag", 1'b1, d[`ECCT_IRQ_PIN]);
        stop_timer();
    endtask

    // Event counting: first edge only arms, second counts
    task automatic t_event();
        logic [7:0] d;
        wr(`ECCT_OFF_CCCTRL, 8'h00);
        wr(`ECCT_OFF_PRESC, 8'h09);
        wr(`ECCT_OFF_EDGE, 8'h01);
        wr(`ECCT_OFF_TCTRL, 8'h01);
        wr(`ECCT_OFF_ICLR, 8'h07);
        rd(`ECCT_OFF_COUNT, d);
        check_byte("no edge count", 8'h00, d);
        pulse(20);
        rd(`ECCT_OFF_COUNT, d);
        check_byte("one edge count", 8'h00, d);
        rd(`ECCT_OFF_STAT, d);
        check_flag("one edge flag", 1'b1, d[`ECCT_IRQ_PIN]);
        pulse(20);
        rd(`ECCT_OFF_COUNT, d);
        check_byte("two edge count", 8'h01, d);
        stop_timer();
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset();
        t_interval(4'h0, 8'h00, 1'b0);
        t_interval(4'h2, 8'h03, 1'b0);
        t_interval(4'h8, 8'h00, 1'b0);
        t_interval(4'h0, 8'hFF, 1'b0);
        t_interval(4'h2, 8'h03, 1'b1);
        t_stop_match();
        t_write_match();
        t_stop();
        t_capture();
        t_event();
        tally_and_finish();
    end
endmodule
